//--- pkg/phprh_pkg.sv
// constants, types and helpers shared by the handshake, parity, reset and hold block
`default_nettype none
package phprh_pkg;
    localparam int unsigned CLK_MHZ        = 100;
    localparam int unsigned RESET_HOLD_US  = 1000;
    localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_US * CLK_MHZ;
    localparam int unsigned TMR_W          = 20;
    localparam int unsigned LOWCNT_W       = 24;
    localparam logic [3:0]  CMD_CFG_RD     = 4'ha;
    localparam logic [3:0]  CMD_CFG_WR     = 4'hb;

    typedef logic [TMR_W-1:0] phprh_tmr_t;

    typedef enum logic [1:0] {
        HOLD_IDLE = 2'b00,
        HOLD_REQ  = 2'b01,
        HOLD_OWN  = 2'b10,
        HOLD_PASS = 2'b11
    } phprh_hold_e;

    typedef struct packed {
        logic par;
        logic oe;
    } phprh_par_s;

    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [2:0]  pg_sync;
        logic        pg_lvl;
        phprh_tmr_t  tmr;
        logic        rst_busy;
        logic        bus_rst_n;
        phprh_hold_e hold;
        logic        hold_n;
        logic        hold_oe;
        logic        granted;
        logic        irdy_n;
        logic        irdy_oe;
        logic        done;
        phprh_par_s  par;
        logic        devsel_n;
        logic        devsel_oe;
    } phprh_state_s;

    localparam phprh_state_s STATE_RST = '{
        hold:     HOLD_IDLE,
        hold_n:   1'b1,
        irdy_n:   1'b1,
        devsel_n: 1'b1,
        default:  '0
    };

    // command/byte-enable lines carry the command during the address phase
    function automatic logic is_cfg_cmd(input logic [3:0] cmd);
        is_cfg_cmd = (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
    endfunction
endpackage
`default_nettype wire

//--- design/phprh_par_gen.sv
// even parity over the 36 address/data and command lines
`default_nettype none
module phprh_par_gen (
    input  wire logic [31:0] ad_i,
    input  wire logic [3:0]  cbe_n_i,
    output logic             par_o
);
    // xor of all bits gives the bit that makes the total even
    assign par_o = ^{ad_i, cbe_n_i};
endmodule
`default_nettype wire

//--- design/phprh_top.sv
// handshake, parity, bus reset and hold request logic on the bus clock
`default_nettype none
module phprh_top #(
    parameter int unsigned RESET_HOLD_CYC = phprh_pkg::RESET_HOLD_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        power_good_i,
    input  wire logic        hard_reset_i,
    input  wire logic        bus_need_i,
    input  wire logic        passive_release_i,
    input  wire logic        bus_hold_grant_n_i,
    input  wire logic        master_active_i,
    input  wire logic        is_init_i,
    input  wire logic        is_write_i,
    input  wire logic        wdata_valid_i,
    input  wire logic        rdata_ready_i,
    input  wire logic        addr_phase_i,
    input  wire logic        idsel_i,
    input  wire logic        ad_oe_i,
    input  wire logic [31:0] ad_i,
    input  wire logic [3:0]  cbe_n_i,
    input  wire logic        bus_irdy_n_i,
    input  wire logic        bus_trdy_n_i,
    output logic             bus_reset_out_n_o,
    output logic             bus_hold_request_n_o,
    output logic             bus_hold_request_oe_o,
    output logic             bus_granted_o,
    output logic             irdy_n_o,
    output logic             irdy_oe_o,
    output logic             phase_done_o,
    output logic             par_o,
    output logic             par_oe_o,
    output logic             devsel_n_o,
    output logic             devsel_oe_o
);
    phprh_pkg::phprh_state_s q;
    phprh_pkg::phprh_state_s d;
    logic                    par_bit;
    logic                    rst_ok;
    logic                    pg_rise;
    logic                    cfg_claim;

    phprh_par_gen u_par (
        .ad_i    (ad_i),
        .cbe_n_i (cbe_n_i),
        .par_o   (par_bit)
    );

    assign rst_ok = q.rst_sync[1];

    always_comb begin
        d = q;
        pg_rise = 1'b0;
        cfg_claim = 1'b0;
        d.rst_sync = {q.rst_sync[0], 1'b1};
        // power good is a pin: three stages, level taken once last two agree
        d.pg_sync = {q.pg_sync[1:0], power_good_i};
        if (q.pg_sync[2] == q.pg_sync[1]) begin
            d.pg_lvl = q.pg_sync[2];
        end
        pg_rise = d.pg_lvl & ~q.pg_lvl;

        if (!rst_ok) begin
            // internal reset: bus reset low, hold request floated
            d.bus_rst_n = 1'b0;
            d.rst_busy = 1'b1;
            d.tmr = phprh_pkg::phprh_tmr_t'(RESET_HOLD_CYC);
            d.hold = phprh_pkg::HOLD_IDLE;
            d.hold_n = 1'b1;
            d.hold_oe = 1'b0;
            d.granted = 1'b0;
            d.irdy_n = 1'b1;
            d.irdy_oe = 1'b0;
            d.done = 1'b0;
            d.par = '0;
            d.devsel_n = 1'b1;
            d.devsel_oe = 1'b0;
        end else begin
            // bus reset timer; a new request reloads it even mid-count
            if (!d.pg_lvl || pg_rise || hard_reset_i) begin
                d.tmr = phprh_pkg::phprh_tmr_t'(RESET_HOLD_CYC);
                d.rst_busy = 1'b1;
            end else if (q.tmr != '0) begin
                d.tmr = q.tmr - phprh_pkg::phprh_tmr_t'(1);
            end else begin
                d.rst_busy = 1'b0;
            end
            d.bus_rst_n = d.pg_lvl & ~d.rst_busy;

            // hold request towards the arbiter
            d.hold_oe = 1'b1;
            case (q.hold)
                phprh_pkg::HOLD_IDLE: begin
                    if (bus_need_i) begin
                        d.hold = phprh_pkg::HOLD_REQ;
                    end
                end
                phprh_pkg::HOLD_REQ: begin
                    if (!bus_need_i) begin
                        d.hold = phprh_pkg::HOLD_IDLE;
                    end else if (!bus_hold_grant_n_i) begin
                        d.hold = phprh_pkg::HOLD_OWN;
                    end
                end
                phprh_pkg::HOLD_OWN: begin
                    // grant is not rechecked: arbiter keeps it while we request
                    if (!bus_need_i) begin
                        d.hold = phprh_pkg::HOLD_IDLE;
                    end else if (passive_release_i) begin
                        d.hold = phprh_pkg::HOLD_PASS;
                    end
                end
                phprh_pkg::HOLD_PASS: begin
                    // one clock high, then request again if still needed
                    d.hold = bus_need_i ? phprh_pkg::HOLD_REQ : phprh_pkg::HOLD_IDLE;
                end
                default: begin
                    d.hold = phprh_pkg::HOLD_IDLE;
                end
            endcase
            d.hold_n = ~((d.hold == phprh_pkg::HOLD_REQ) || (d.hold == phprh_pkg::HOLD_OWN));
            d.granted = (d.hold == phprh_pkg::HOLD_OWN);

            // initiator ready: driven only in a master transfer
            d.irdy_oe = master_active_i;
            d.irdy_n = ~(master_active_i & (is_write_i ? wdata_valid_i : rdata_ready_i));

            // both ready lines low at this edge completes the phase
            d.done = ~bus_irdy_n_i & ~bus_trdy_n_i;

            // parity follows the lines one clock behind, only in the allowed cases
            d.par.par = par_bit;
            d.par.oe = ad_oe_i & (addr_phase_i ? is_init_i : (is_init_i == is_write_i));

            // configuration claim: devsel low the clock after the address phase
            cfg_claim = addr_phase_i & idsel_i & ~is_init_i & phprh_pkg::is_cfg_cmd(cbe_n_i);
            if (cfg_claim) begin
                d.devsel_n = 1'b0;
                d.devsel_oe = 1'b1;
            end else if (!q.devsel_n && d.done) begin
                // limitation: released on first completed phase, single-phase config only
                d.devsel_n = 1'b1;
                d.devsel_oe = 1'b0;
            end
        end
    end

    // async clear on the raw pin drives bus reset low at once, off the clock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= phprh_pkg::STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign bus_reset_out_n_o = q.bus_rst_n;
    assign bus_hold_request_n_o = q.hold_n;
    assign bus_hold_request_oe_o = q.hold_oe;
    assign bus_granted_o = q.granted;
    assign irdy_n_o = q.irdy_n;
    assign irdy_oe_o = q.irdy_oe;
    assign phase_done_o = q.done;
    assign par_o = q.par.par;
    assign par_oe_o = q.par.oe;
    assign devsel_n_o = q.devsel_n;
    assign devsel_oe_o = q.devsel_oe;

    // helper: length of the current bus reset low period
    logic [phprh_pkg::LOWCNT_W-1:0] low_cnt_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt_q <= '0;
        end else if (q.bus_rst_n) begin
            low_cnt_q <= '0;
        end else if (low_cnt_q != '1) begin
            low_cnt_q <= low_cnt_q + phprh_pkg::LOWCNT_W'(1);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_ok);

    a_phase_done_flag: assert property (
        1'b1 |=> phase_done_o == $past(!bus_irdy_n_i && !bus_trdy_n_i)
    ) else $error("phase done does not follow both ready lines");

    a_irdy_write_wait: assert property (
        (master_active_i && is_write_i && !wdata_valid_i) |=> irdy_n_o
    ) else $error("initiator ready asserted without write data");

    a_irdy_read_ready: assert property (
        (master_active_i && !is_write_i && rdata_ready_i) |=> !irdy_n_o && irdy_oe_o
    ) else $error("initiator ready missing when ready to read");

    a_irdy_float: assert property (
        !master_active_i |=> !irdy_oe_o
    ) else $error("initiator ready driven outside master transfer");

    a_par_even: assert property (
        $past(rst_ok) && par_oe_o |-> (^{par_o, $past(ad_i), $past(cbe_n_i)}) == 1'b0
    ) else $error("parity not even over the 36 bits");

    a_par_addr_out: assert property (
        (ad_oe_i && addr_phase_i && is_init_i) |=> par_oe_o
    ) else $error("parity not driven after own address phase");

    a_par_target_wr: assert property (
        (!addr_phase_i && !is_init_i && is_write_i) |=> !par_oe_o
    ) else $error("parity driven on target write data");

    a_par_float: assert property (
        !ad_oe_i |=> !par_oe_o
    ) else $error("parity driven a clock after lines floated");

    a_reset_pg_low: assert property (
        !q.pg_lvl |=> !bus_reset_out_n_o
    ) else $error("bus reset released while power good low");

    a_reset_min_len: assert property (
        $rose(bus_reset_out_n_o) |-> $past(low_cnt_q) >= phprh_pkg::LOWCNT_W'(RESET_HOLD_CYC)
    ) else $error("bus reset low period shorter than 1 ms");

    a_reset_on_request: assert property (
        hard_reset_i |=> !bus_reset_out_n_o [*2]
    ) else $error("hard reset request did not assert bus reset");

    sequence s_release_req;
        (q.hold == phprh_pkg::HOLD_OWN) && bus_need_i && passive_release_i;
    endsequence

    sequence s_one_clock_gap;
        bus_hold_request_n_o ##1 !bus_hold_request_n_o;
    endsequence

    a_passive_one: assert property (
        s_release_req ##1 bus_need_i |-> s_one_clock_gap
    ) else $error("passive release gap is not one clock");

    a_hold_after_rst: assert property (
        $rose(rst_ok) |=> bus_hold_request_oe_o && bus_hold_request_n_o
    ) else $error("hold request not driven high after reset");

    a_grant_owns: assert property (
        ((q.hold == phprh_pkg::HOLD_REQ) && bus_need_i && !bus_hold_grant_n_i) |=> bus_granted_o
    ) else $error("low grant not taken as ownership");

    a_request_low: assert property (
        (bus_need_i && (q.hold == phprh_pkg::HOLD_IDLE)) |=> !bus_hold_request_n_o
    ) else $error("hold request not driven low on need");

    a_devsel_claim: assert property (
        (addr_phase_i && idsel_i && !is_init_i && phprh_pkg::is_cfg_cmd(cbe_n_i)) |=> !devsel_n_o && devsel_oe_o
    ) else $error("configuration cycle not claimed next clock");

    sequence s_both_ready;
        !bus_irdy_n_i && !bus_trdy_n_i;
    endsequence

    sequence s_pg_low3;
        !power_good_i [*3];
    endsequence

    a_done_set: assert property (
        s_both_ready |=> phase_done_o
    ) else $error("phase done missing after both ready lines low");

    a_irdy_write_go: assert property (
        (master_active_i && is_write_i && wdata_valid_i) |=> !irdy_n_o && irdy_oe_o
    ) else $error("initiator ready missing with valid write data");

    a_irdy_read_wait: assert property (
        (master_active_i && !is_write_i && !rdata_ready_i) |=> irdy_n_o
    ) else $error("initiator ready asserted before read capture ready");

    a_irdy_master_drv: assert property (
        master_active_i |=> irdy_oe_o
    ) else $error("initiator ready not driven in master transfer");

    a_irdy_idle_high: assert property (
        !irdy_oe_o |-> irdy_n_o
    ) else $error("initiator ready low while not driven");

    a_par_init_write: assert property (
        (ad_oe_i && !addr_phase_i && is_init_i && is_write_i) |=> par_oe_o
    ) else $error("parity not driven after initiator write data");

    a_par_target_read: assert property (
        (ad_oe_i && !addr_phase_i && !is_init_i && !is_write_i) |=> par_oe_o
    ) else $error("parity not driven after target read data");

    a_par_init_read: assert property (
        (!addr_phase_i && is_init_i && !is_write_i) |=> !par_oe_o
    ) else $error("parity driven on initiator read data");

    a_par_addr_target: assert property (
        (addr_phase_i && !is_init_i) |=> !par_oe_o
    ) else $error("parity driven on foreign address phase");

    a_par_value: assert property (
        par_oe_o |-> par_o == ^{$past(ad_i), $past(cbe_n_i)}
    ) else $error("parity not taken over all 36 lines of last clock");

    a_reset_tmr_load: assert property (
        hard_reset_i |=> (q.tmr == phprh_pkg::phprh_tmr_t'(RESET_HOLD_CYC)) && q.rst_busy
    ) else $error("hard reset request did not load the full hold time");

    a_reset_busy_low: assert property (
        q.rst_busy |-> !bus_reset_out_n_o
    ) else $error("bus reset released while hold time running");

    a_reset_pin_low: assert property (
        s_pg_low3 |=> ##1 !bus_reset_out_n_o
    ) else $error("bus reset not low after power good pin low");

    a_bus_rst_in_rst: assert property (
        disable iff (!rst_n_i) !rst_ok |=> !bus_reset_out_n_o
    ) else $error("bus reset high during internal reset");

    a_hold_float_rst: assert property (
        disable iff (!rst_n_i) !rst_ok |=> !bus_hold_request_oe_o
    ) else $error("hold request driven during internal reset");

    a_hold_oe_run: assert property (
        rst_ok |=> bus_hold_request_oe_o
    ) else $error("hold request floated after reset");

    a_grant_drop: assert property (
        s_release_req |=> !bus_granted_o && bus_hold_request_n_o
    ) else $error("ownership kept during passive release");

    a_no_grant_wait: assert property (
        ((q.hold == phprh_pkg::HOLD_REQ) && bus_hold_grant_n_i) |=> !bus_granted_o
    ) else $error("ownership taken without low grant");

    a_request_drop: assert property (
        !bus_need_i |=> bus_hold_request_n_o && !bus_granted_o
    ) else $error("hold request kept low without need");

    a_devsel_release: assert property (
        (!devsel_n_o && !bus_irdy_n_i && !bus_trdy_n_i && !cfg_claim) |=> devsel_n_o && !devsel_oe_o
    ) else $error("device select not released after completed phase");

    a_devsel_no_claim: assert property (
        (devsel_n_o && !(addr_phase_i && idsel_i)) |=> devsel_n_o
    ) else $error("device select asserted without configuration claim");
endmodule
`default_nettype wire

//--- tb/phprh_arb_model.sv
// hold arbiter model facing the hold request line
`default_nettype none
module phprh_arb_model (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       req_n_i,
    input  wire logic       req_oe_i,
    input  wire logic [3:0] dly_i,
    output logic            grant_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       req_n;
    logic [3:0] cnt_q;
    // a floating request line reads high through its pull-up
    assign req_n = req_oe_i ? req_n_i : 1'b1;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grant_n_o <= 1'b1;
            cnt_q     <= 4'h0;
        end else if (req_n) begin
            grant_n_o <= 1'b1;
            cnt_q     <= 4'h0;
        end else if (cnt_q >= dly_i) begin
            grant_n_o <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

//--- tb/phprh_tb_top.sv
// self-checking bench for the handshake, parity, bus reset and hold block
`default_nettype none
module phprh_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned H = 20;
    localparam logic [4:0] PT [6] = '{5'b11101, 5'b10111, 5'b10001, 5'b01100, 5'b10100, 5'b10010};
    logic        clk, rst_n, pg, hrst, need, prel, mact, init, wr, wval, rrdy, aph, idsel, adoe;
    logic        tb_irdy_n, trdy_n, bus_irdy_n, grant_n, bus_rst_n, req_n, req_oe, granted;
    logic        irdy_n, irdy_oe, done, par, par_oe, devsel_n, devsel_oe;
    logic [31:0] ad;
    logic [3:0]  cbe, dly;
    int          n_errors, num_checks;
    // resolved ready line: our driver wins while enabled, else the other agent
    assign bus_irdy_n = irdy_oe ? irdy_n : tb_irdy_n;
    phprh_top #(.RESET_HOLD_CYC(H)) dut (.clk_i(clk), .rst_n_i(rst_n), .power_good_i(pg), .hard_reset_i(hrst),
        .bus_need_i(need), .passive_release_i(prel), .bus_hold_grant_n_i(grant_n), .master_active_i(mact),
        .is_init_i(init), .is_write_i(wr), .wdata_valid_i(wval), .rdata_ready_i(rrdy), .addr_phase_i(aph),
        .idsel_i(idsel), .ad_oe_i(adoe), .ad_i(ad), .cbe_n_i(cbe), .bus_irdy_n_i(bus_irdy_n),
        .bus_trdy_n_i(trdy_n), .bus_reset_out_n_o(bus_rst_n), .bus_hold_request_n_o(req_n),
        .bus_hold_request_oe_o(req_oe), .bus_granted_o(granted), .irdy_n_o(irdy_n), .irdy_oe_o(irdy_oe),
        .phase_done_o(done), .par_o(par), .par_oe_o(par_oe), .devsel_n_o(devsel_n), .devsel_oe_o(devsel_oe));
    phprh_arb_model arb (.clk_i(clk), .rst_n_i(rst_n), .req_n_i(req_n), .req_oe_i(req_oe), .dly_i(dly),
        .grant_n_o(grant_n));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wait_rel(output int c);
        c = 0;
        while (bus_rst_n !== 1'b1) begin
            cyc(1);
            c++;
            if (c > 200) begin
                n_errors++;
                end_sim();
            end
        end
    endtask
    task automatic t_power();
        int c;
        cyc(40);
        chk("rst_pg_low", 32'(bus_rst_n), 32'h0);
        chk("req_idle", 32'({req_oe, req_n}), 32'h3);
        pg = 1'b1;
        wait_rel(c);
        chk("pg_hold", 32'(c >= H && c <= H + 8), 32'h1);
        $display("t_power done");
    endtask
    task automatic t_hard();
        int c;
        hrst = 1'b1;
        cyc(1);
        hrst = 1'b0;
        chk("hard_rst", 32'(bus_rst_n), 32'h0);
        wait_rel(c);
        chk("hard_hold", 32'(c + 1 >= H && c <= H + 4), 32'h1);
        $display("t_hard done");
    endtask
    task automatic t_hold(input logic [3:0] d);
        int c;
        dly = d;
        need = 1'b1;
        cyc(1);
        chk("req_low", 32'(req_n), 32'h0);
        c = 0;
        while (granted !== 1'b1) begin
            cyc(1);
            c++;
            if (c > 30) begin
                n_errors++;
                end_sim();
            end
        end
        chk("grant_low", 32'(grant_n), 32'h0);
        prel = 1'b1;
        cyc(1);
        prel = 1'b0;
        chk("rel_high", 32'(req_n), 32'h1);
        chk("rel_grant", 32'(granted), 32'h0);
        cyc(1);
        chk("rel_back", 32'(req_n), 32'h0);
        need = 1'b0;
        cyc(2);
        chk("req_drop", 32'({req_oe, req_n}), 32'h3);
        cyc(2);
        $display("t_hold done");
    endtask
    task automatic t_irdy();
        mact = 1'b1;
        wr = 1'b1;
        cyc(1);
        chk("irdy_oe", 32'({irdy_oe, irdy_n}), 32'h3);
        wval = 1'b1;
        cyc(1);
        chk("irdy_wr", 32'(irdy_n), 32'h0);
        {wr, wval, rrdy, trdy_n} = 4'h2;
        cyc(1);
        chk("done_wr", 32'({done, irdy_n}), 32'h2);
        {mact, rrdy, trdy_n} = 3'h1;
        cyc(1);
        chk("irdy_float", 32'(irdy_oe), 32'h0);
        {tb_irdy_n, trdy_n} = 2'h0;
        cyc(1);
        chk("done_tgt", 32'(done), 32'h1);
        {tb_irdy_n, trdy_n} = 2'h3;
        cyc(1);
        $display("t_irdy done");
    endtask
    task automatic t_par();
        logic e;
        for (int i = 0; i < 6; i++) begin
            {adoe, aph, init, wr} = PT[i][4:1];
            ad = 32'h0123_4567 ^ (32'h1 << i);
            cbe = 4'(i);
            e = ^{ad, cbe};
            cyc(1);
            chk("par_oe", 32'(par_oe), 32'(PT[i][0]));
            if (PT[i][0]) begin
                chk("par", 32'(par), 32'(e));
                chk("par_even", 32'(^{ad, cbe, par}), 32'h0);
            end
        end
        {adoe, aph, init, wr} = 4'h0;
        cyc(1);
        $display("t_par done");
    endtask
    task automatic t_dev();
        logic [3:0] cmd [3] = '{4'ha, 4'hb, 4'h6};
        for (int i = 0; i < 3; i++) begin
            {aph, idsel, cbe} = {2'b11, cmd[i]};
            cyc(1);
            chk("devsel", 32'({devsel_oe, devsel_n}), (i < 2) ? 32'h2 : 32'h1);
            {aph, idsel, tb_irdy_n, trdy_n} = 4'h0;
            cyc(1);
            chk("done_cfg", 32'(done), 32'h1);
            chk("devsel_free", 32'({devsel_oe, devsel_n}), 32'h1);
            {tb_irdy_n, trdy_n} = 2'h3;
            cyc(2);
        end
        $display("t_dev done");
    endtask
    task automatic t_rst();
        int c;
        rst_n = 1'b0;
        // look before any clock edge: bus reset must fall off the clock
        #2;
        chk("rst_async", 32'({bus_rst_n, req_oe}), 32'h0);
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
        chk("rst_sync_hold", 32'({req_oe, req_n}), 32'h1);
        cyc(1);
        chk("req_after", 32'({req_oe, req_n}), 32'h3);
        wait_rel(c);
        chk("pg_rel", 32'(c + 3 >= H && c <= H + 5), 32'h1);
        $display("t_rst done");
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        n_errors = 0;
        num_checks = 0;
        {rst_n, pg, hrst, need, prel, mact, init, wr, wval, rrdy, aph, idsel, adoe} = 13'h0;
        {tb_irdy_n, trdy_n, ad, cbe, dly} = {2'h3, 40'h0};
        cyc(20);
        chk("rst_out", 32'({bus_rst_n, req_oe, irdy_oe, par_oe}), 32'h0);
        rst_n = 1'b1;
        t_power();
        t_hard();
        t_hold(4'h0);
        t_hold(4'h5);
        t_irdy();
        t_par();
        t_dev();
        t_rst();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
